// *** ppl_loop.sv ***
// Two-channel closed-loop position controller with shared gains and emergency stop.
// Assumes synchronous inputs; positions are signed with mid travel as zero.
`timescale 1ns/10ps
module ppl_loop
	import ppl_pkg::*;
#(
	parameter int unsigned PERIOD_CYC = PPL_PERIOD_CYC
)
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire ppl_mode_t mode,
	input wire ppl_gains_t gains,
	input wire logic estop,
	input wire logic signed [PPL_POS_W-1:0] dest_a,
	input wire logic signed [PPL_POS_W-1:0] dest_b,
	input wire logic signed [PPL_POS_W-1:0] meas_a,
	input wire logic signed [PPL_POS_W-1:0] meas_b,
	output ppl_drive_t drive_a,
	output ppl_drive_t drive_b,
	output logic tick_r
);
	localparam int DIV_W = $clog2(PERIOD_CYC);
	logic [DIV_W-1:0] div_r;
	logic [DIV_W:0] gap_r;
	logic estop_r;
	logic [PPL_CH_N-1:0] run;
	logic signed [PPL_POS_W-1:0] dest [PPL_CH_N];
	logic signed [PPL_POS_W-1:0] meas [PPL_CH_N];
	ppl_drive_t drv [PPL_CH_N];
	logic signed [PPL_SUM_W-1:0] sum [PPL_CH_N];
	logic signed [PPL_POS_W:0] err_now [PPL_CH_N];
	logic signed [PPL_POS_W:0] seen_err_r [PPL_CH_N];

	function automatic logic pos_mode_on(input ppl_mode_t m, input int ch);
		if (ch == PPL_CH_B) begin
			pos_mode_on = (m != PPL_MODE_NONE);
		end else begin
			pos_mode_on = (m == PPL_MODE_AB_POS);
		end
	endfunction

	// Expected drive of a pure proportional step, clamped to full scale
	function automatic ppl_drive_t prop_drive(input logic signed [PPL_POS_W:0] e,
		input ppl_gains_t g);
		logic signed [PPL_SUM_W-1:0] p;
		ppl_drive_t d;
		p = PPL_SUM_W'(e * $signed({1'b0, g.kp}));
		if (p > PPL_PWR_MAX) begin
			p = PPL_PWR_MAX;
		end else if (p < PPL_PWR_MIN) begin
			p = PPL_PWR_MIN;
		end
		d.enable = 1'b1;
		d.reverse = p[PPL_SUM_W-1];
		d.magnitude = p[PPL_SUM_W-1] ? (PPL_PWR_W-1)'(-p) : (PPL_PWR_W-1)'(p);
		return d;
	endfunction

	// Control period tick
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else if (div_r == DIV_W'(PERIOD_CYC - 1)) begin
			div_r <= '0;
			tick_r <= 1'b1;
		end else begin
			div_r <= div_r + 1'b1;
			tick_r <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			estop_r <= 1'b0;
		end else begin
			estop_r <= estop;
		end
	end

	// Cycles since the last tick, an independent count for the period check
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			gap_r <= '0;
		end else if (tick_r) begin
			gap_r <= (DIV_W+1)'(1);
		end else if (gap_r != '1) begin
			gap_r <= gap_r + 1'b1;
		end
	end

	assign dest[PPL_CH_A] = dest_a;
	assign dest[PPL_CH_B] = dest_b;
	assign meas[PPL_CH_A] = meas_a;
	assign meas[PPL_CH_B] = meas_b;

	for (genvar c = 0; c < PPL_CH_N; c++) begin : g_ch
		// One stop level gates every channel at once
		assign run[c] = pos_mode_on(mode, c) && !estop && !estop_r;
		ppl_chan u_chan (
			.mclk(mclk),
			.rst_b(rst_b),
			.tick(tick_r),
			.run(run[c]),
			.gains(gains),
			.dest(dest[c]),
			.meas(meas[c]),
			.drive(drv[c]),
			.sum_r(sum[c])
		);
		// Error seen at the last running tick, cleared while stopped
		assign err_now[c] = (PPL_POS_W+1)'(dest[c]) - (PPL_POS_W+1)'(meas[c]);
		always_ff @(posedge mclk or negedge rst_b) begin
			if (!rst_b) begin
				seen_err_r[c] <= '0;
			end else if (!run[c]) begin
				seen_err_r[c] <= '0;
			end else if (tick_r) begin
				seen_err_r[c] <= err_now[c];
			end
		end
	end

	assign drive_a = drv[PPL_CH_A];
	assign drive_b = drv[PPL_CH_B];

	property p_stop_off;
		@(posedge mclk) disable iff (!rst_b)
		estop |=> (!drive_a.enable && !drive_b.enable);
	endproperty
	a_stop_off: assert property (p_stop_off) else $error("drive on during stop");

	property p_tick_period;
		@(posedge mclk) disable iff (!rst_b)
		tick_r |=> !tick_r [*8];
	endproperty
	a_tick_period: assert property (p_tick_period) else $error("tick too close");

	sequence s_steady;
		tick_r && run[PPL_CH_B] && gains.ki == '0
			&& err_now[PPL_CH_B] == seen_err_r[PPL_CH_B];
	endsequence

	sequence s_steady_a;
		tick_r && run[PPL_CH_A] && gains.ki == '0
			&& err_now[PPL_CH_A] == seen_err_r[PPL_CH_A];
	endsequence

	property p_prop_b;
		@(posedge mclk) disable iff (!rst_b)
		s_steady |=> drive_b == prop_drive($past(err_now[PPL_CH_B]), $past(gains));
	endproperty
	a_prop_b: assert property (p_prop_b) else $error("B power not error times gain");

	property p_prop_a;
		@(posedge mclk) disable iff (!rst_b)
		s_steady_a |=> drive_a == prop_drive($past(err_now[PPL_CH_A]), $past(gains));
	endproperty
	a_prop_a: assert property (p_prop_a) else $error("A power not error times gain");

	property p_zero_err;
		@(posedge mclk) disable iff (!rst_b)
		(s_steady and (err_now[PPL_CH_B] == '0)) |=> drive_b.magnitude == '0;
	endproperty
	a_zero_err: assert property (p_zero_err) else $error("power with zero error");

	property p_sign;
		@(posedge mclk) disable iff (!rst_b)
		(tick_r && run[PPL_CH_B]) |=> drive_b.reverse == sum[PPL_CH_B][PPL_SUM_W-1];
	endproperty
	a_sign: assert property (p_sign) else $error("direction mismatch");

	property p_clamp;
		@(posedge mclk) disable iff (!rst_b)
		sum[PPL_CH_A] <= PPL_PWR_MAX && sum[PPL_CH_A] >= PPL_PWR_MIN;
	endproperty
	a_clamp: assert property (p_clamp) else $error("output beyond full scale");

	property p_mode_a;
		@(posedge mclk) disable iff (!rst_b)
		(mode != PPL_MODE_AB_POS) |=> !drive_a.enable;
	endproperty
	a_mode_a: assert property (p_mode_a) else $error("channel A driven outside mode");

	property p_mode_b;
		@(posedge mclk) disable iff (!rst_b)
		(mode == PPL_MODE_NONE) |=> !drive_b.enable;
	endproperty
	a_mode_b: assert property (p_mode_b) else $error("channel B driven outside mode");

	property p_tick_gap;
		@(posedge mclk) disable iff (!rst_b)
		tick_r == (gap_r == (DIV_W+1)'(PERIOD_CYC));
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("tick off its period");

	property p_hold_a;
		@(posedge mclk) disable iff (!rst_b)
		(!tick_r && run[PPL_CH_A]) |=> $stable(drive_a);
	endproperty
	a_hold_a: assert property (p_hold_a) else $error("A drive moved off tick");

	property p_hold_b;
		@(posedge mclk) disable iff (!rst_b)
		(!tick_r && run[PPL_CH_B]) |=> $stable(drive_b);
	endproperty
	a_hold_b: assert property (p_hold_b) else $error("B drive moved off tick");

	property p_resume;
		@(posedge mclk) disable iff (!rst_b)
		($rose(drive_a.enable) || $rose(drive_b.enable)) |-> (!$past(estop) && !$past(estop_r));
	endproperty
	a_resume: assert property (p_resume) else $error("drive resumed during stop");

	property p_stop_late;
		@(posedge mclk) disable iff (!rst_b)
		(estop_r && !estop) |=> (!drive_a.enable && !drive_b.enable);
	endproperty
	a_stop_late: assert property (p_stop_late) else $error("drive on at stop release");

	property p_sign_a;
		@(posedge mclk) disable iff (!rst_b)
		(tick_r && run[PPL_CH_A]) |=> drive_a.reverse == sum[PPL_CH_A][PPL_SUM_W-1];
	endproperty
	a_sign_a: assert property (p_sign_a) else $error("A direction mismatch");
endmodule

// *** ppl_pkg.sv ***
// Package for the two-channel PID position loop: constants, modes and carriers.
// Assumes one 25 MHz clock and signed 8-bit positions centred on zero.
package ppl_pkg;
	localparam int unsigned PPL_CLK_HZ = 25000000;
	localparam int unsigned PPL_PERIOD_MS = 16;
	localparam int unsigned PPL_PERIOD_CYC = PPL_CLK_HZ / 1000 * PPL_PERIOD_MS;
	localparam int PPL_POS_W = 8;
	localparam int PPL_GAIN_W = 8;
	localparam int PPL_ACC_W = 16;
	localparam int PPL_SUM_W = 28;
	localparam int PPL_PWR_W = 8;
	localparam logic signed [PPL_SUM_W-1:0] PPL_PWR_MAX = 28'sh000007F;
	localparam logic signed [PPL_SUM_W-1:0] PPL_PWR_MIN = -28'sh000007F;
	localparam logic signed [PPL_ACC_W-1:0] PPL_ACC_MAX = 16'sh7FFF;
	localparam logic signed [PPL_ACC_W-1:0] PPL_ACC_MIN = -16'sh7FFF;
	localparam int PPL_CH_N = 2;
	localparam int PPL_CH_A = 0;
	localparam int PPL_CH_B = 1;

	typedef enum logic [1:0] {
		PPL_MODE_A_OPEN_B_POS,
		PPL_MODE_A_CLOSED_B_POS,
		PPL_MODE_AB_POS,
		PPL_MODE_NONE
	} ppl_mode_t;

	typedef struct packed {
		logic [PPL_GAIN_W-1:0] kp;
		logic [PPL_GAIN_W-1:0] ki;
		logic [PPL_GAIN_W-1:0] kd;
	} ppl_gains_t;

	typedef struct packed {
		logic enable;
		logic reverse;
		logic [PPL_PWR_W-2:0] magnitude;
	} ppl_drive_t;
endpackage

// *** ppl_chan.sv ***
// One position loop channel: error, history, integral, PID sum and clamp.
// Assumes the caller supplies a one-cycle tick per control period.
`timescale 1ns/10ps
module ppl_chan
	import ppl_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic run,
	input wire ppl_gains_t gains,
	input wire logic signed [PPL_POS_W-1:0] dest,
	input wire logic signed [PPL_POS_W-1:0] meas,
	output ppl_drive_t drive,
	output logic signed [PPL_SUM_W-1:0] sum_r
);
	logic signed [PPL_POS_W:0] err;
	logic signed [PPL_POS_W:0] prev_err_r;
	logic signed [PPL_POS_W+1:0] derr;
	logic signed [PPL_ACC_W-1:0] acc_r;
	logic signed [PPL_ACC_W:0] acc_wide;
	logic signed [PPL_ACC_W-1:0] acc_nxt;
	logic signed [PPL_SUM_W-1:0] sum_nxt;
	logic signed [PPL_SUM_W-1:0] clamped;

	always_comb begin
		err = PPL_POS_W'(0) + (PPL_POS_W+1)'(dest) - (PPL_POS_W+1)'(meas);
		derr = (PPL_POS_W+2)'(err) - (PPL_POS_W+2)'(prev_err_r);
		acc_wide = (PPL_ACC_W+1)'(acc_r) + (PPL_ACC_W+1)'(err);
		if (acc_wide > (PPL_ACC_W+1)'(PPL_ACC_MAX)) begin
			acc_nxt = PPL_ACC_MAX;
		end else if (acc_wide < (PPL_ACC_W+1)'(PPL_ACC_MIN)) begin
			acc_nxt = PPL_ACC_MIN;
		end else begin
			acc_nxt = acc_wide[PPL_ACC_W-1:0];
		end
		sum_nxt = PPL_SUM_W'(err * $signed({1'b0, gains.kp}))
			+ PPL_SUM_W'(derr * $signed({1'b0, gains.kd}))
			+ PPL_SUM_W'(acc_nxt * $signed({1'b0, gains.ki}));
		if (sum_nxt > PPL_PWR_MAX) begin
			clamped = PPL_PWR_MAX;
		end else if (sum_nxt < PPL_PWR_MIN) begin
			clamped = PPL_PWR_MIN;
		end else begin
			clamped = sum_nxt;
		end
	end

	// History and integral clear while stopped so restart is clean
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			prev_err_r <= '0;
			acc_r <= '0;
			sum_r <= '0;
		end else if (!run) begin
			prev_err_r <= '0;
			acc_r <= '0;
			sum_r <= '0;
		end else if (tick) begin
			prev_err_r <= err;
			acc_r <= acc_nxt;
			sum_r <= clamped;
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			drive <= '0;
		end else if (!run) begin
			drive <= '0;
		end else if (tick) begin
			drive.enable <= 1'b1;
			drive.reverse <= clamped[PPL_SUM_W-1];
			drive.magnitude <= clamped[PPL_SUM_W-1] ? (PPL_PWR_W-1)'(-clamped)
				: (PPL_PWR_W-1)'(clamped);
		end
	end

endmodule

// *** ppl_plant.sv ***
// Partner model: absolute position sensor and motor power stage of one channel.
// Assumes the bench sets the axle position; no motion dynamics are modelled.
`timescale 1ns/10ps
module ppl_plant
	import ppl_pkg::*;
(
	input wire logic mclk,
	input wire ppl_drive_t drive,
	input wire logic signed [PPL_POS_W-1:0] pos,
	output logic signed [PPL_POS_W-1:0] meas,
	output logic signed [PPL_PWR_W-1:0] power
);
	// Mid travel reads zero
	always_ff @(posedge mclk) begin
		meas <= pos;
	end
	// Signed power applied to the motor, none while disabled
	// Stage current limit is configured low outside the loop and not modelled
	always_comb begin
		power = '0;
		if (drive.enable) begin
			power = drive.reverse ? -{1'b0, drive.magnitude} : {1'b0, drive.magnitude};
		end
	end
endmodule

// *** ppl_loop_test.sv ***
// Self-checking bench for the two-channel position loop.
// Assumes a shortened control period; each scenario waits on tick_r.
`timescale 1ns/10ps
module ppl_loop_test;
	import ppl_pkg::*;
	// Short period keeps the run brief; the device default stays 16 ms
	localparam int unsigned TB_PERIOD = 50;
	logic mclk = 0;
	logic rst_b = 0;
	logic estop = 0;
	ppl_mode_t mode = PPL_MODE_AB_POS;
	ppl_gains_t gains = '0;
	logic signed [7:0] dest_a = 0, dest_b = 0, pos_a = 0, pos_b = 0, meas_a, meas_b;
	ppl_drive_t drive_a, drive_b;
	logic tick_r;
	int bad_count = 0;
	int n_checks = 0;
	always #20 mclk = ~mclk;
	ppl_plant pa (.mclk(mclk), .drive(drive_a), .pos(pos_a), .meas(meas_a), .power());
	ppl_plant pb (.mclk(mclk), .drive(drive_b), .pos(pos_b), .meas(meas_b), .power());
	ppl_loop #(.PERIOD_CYC(TB_PERIOD)) DUT (.mclk(mclk), .rst_b(rst_b), .mode(mode),
		.gains(gains), .estop(estop),
		.dest_a(dest_a), .dest_b(dest_b), .meas_a(meas_a), .meas_b(meas_b),
		.drive_a(drive_a), .drive_b(drive_b), .tick_r(tick_r));
	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t drive %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [8:0] dv(input int v);
		return {1'b1, v < 0, 7'(v < 0 ? -v : v)};
	endfunction
	// Destinations stay within the sensor range
	task automatic set(input int kp, ki, kd, da, ma, db, mb);
		@(posedge mclk);
		gains <= {8'(kp), 8'(ki), 8'(kd)};
		dest_a <= 8'(da);
		pos_a <= 8'(ma);
		dest_b <= 8'(db);
		pos_b <= 8'(mb);
	endtask
	task automatic step;
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (tick_r !== 1'b1 && n < 2 * TB_PERIOD);
		if (n >= 2 * TB_PERIOD) begin
			bad_count++;
			$display("ERROR %0t no tick", $time);
		end
		@(posedge mclk);
		#1;
	endtask
	task automatic s_tick;
		int n;
		step();
		n = 1;
		do begin
			@(posedge mclk);
			#1;
			n++;
		end while (tick_r !== 1'b1 && n < 2 * TB_PERIOD);
		chk(9'(n), 9'(TB_PERIOD));
	endtask
	task automatic s_prop;
		set(2, 0, 0, 10, 4, -6, 4);
		step();
		chk(drive_a, dv(12));
		chk(drive_b, dv(-20));
		set(255, 0, 0, 10, 4, -6, 4);
		step();
		chk(drive_a, dv(127));
		chk(drive_b, dv(-127));
	endtask
	task automatic s_stop_pid;
		@(posedge mclk);
		estop <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		chk(drive_a, '0);
		chk(drive_b, '0);
		set(0, 0, 1, 10, 4, 0, 0);
		@(posedge mclk);
		estop <= 1'b0;
		step();
		chk(drive_a, dv(6));
		set(0, 0, 1, 13, 4, 0, 0);
		step();
		chk(drive_a, dv(3));
		set(0, 1, 0, 13, 4, 0, 0);
		step();
		chk(drive_a, dv(24));
	endtask
	task automatic s_mode;
		@(posedge mclk);
		mode <= PPL_MODE_A_OPEN_B_POS;
		set(1, 0, 0, 5, 0, 5, 0);
		step();
		chk(drive_a, '0);
		chk(drive_b, dv(5));
		@(posedge mclk);
		mode <= PPL_MODE_A_CLOSED_B_POS;
		set(1, 0, 0, 7, 0, -3, 0);
		step();
		chk(drive_a, '0);
		chk(drive_b, dv(-3));
		@(posedge mclk);
		mode <= PPL_MODE_NONE;
		repeat (3) @(posedge mclk);
		#1;
		chk(drive_b, '0);
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#(40.0 * TB_PERIOD * 40);
		bad_count++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge mclk);
		rst_b <= 1'b1;
		s_tick();
		s_prop();
		s_stop_pid();
		s_mode();
		close_out();
	end
endmodule
